// *** arpct_defs.svh ***
`ifndef ARPCT_DEFS_SVH
`define ARPCT_DEFS_SVH

// Register indices; byte address is four times the index
`define ARPCT_IDX_MODE    8'hd5
`define ARPCT_IDX_STATUS  8'hd6
`define ARPCT_IDX_CONFIG  8'hd7
`define ARPCT_IDX_RELOAD  8'hd9
`define ARPCT_IDX_COMPARE 8'hda
`define ARPCT_IDX_LOAD    8'hdb

// Mode control register fields
`define ARPCT_MC_LOAD_TRIG 7
`define ARPCT_MC_COUNT_EN  6
`define ARPCT_MC_PWM_OE    5
`define ARPCT_MC_EDGE_IE   4
`define ARPCT_MC_CMP_IE    3
`define ARPCT_MC_OVF_IE    2
`define ARPCT_MC_MODE_HI   1
`define ARPCT_MC_MODE_LO   0

// Status register fields
`define ARPCT_ST_EDGE 2
`define ARPCT_ST_CMP  1
`define ARPCT_ST_OVF  0

// Clock and edge configuration fields
`define ARPCT_CF_PS_HI   7
`define ARPCT_CF_PS_LO   5
`define ARPCT_CF_POL     3
`define ARPCT_CF_EDGE_EN 2
`define ARPCT_CF_CS_HI   1
`define ARPCT_CF_CS_LO   0

// Reset values
`define ARPCT_RST_MODE    8'h00
`define ARPCT_RST_CONFIG  8'h00
`define ARPCT_RST_RELOAD  8'h00
`define ARPCT_RST_COMPARE 8'h00
`define ARPCT_RST_COUNTER 8'h00

// Timing counts: the divide-by-three source ticks on the last of three cycles
`define ARPCT_DIV3_LAST 2'h2

`endif

// *** arpct_far_end.sv ***
`timescale 1ns/1ps
module arpct_far_end
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // Source control: level, or a free clock of half period
  input wire logic         lvl,
  input wire logic [3:0]   half,
  // Pins
  input wire logic         pwm_pin,
  output logic             timer_in,
  // Measured load waveform
  output logic [15:0]      period,
  output logic [15:0]      high_len
);
  logic [3:0]  div_ff;
  logic [15:0] cnt_ff;
  logic        last_ff;
  // The source always drives; it runs as a clock only when asked
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      {div_ff, cnt_ff, last_ff, timer_in, period, high_len} <= '0;
    end
    else
    begin
      if (half == 4'h0)
        timer_in <= lvl;
      else if (div_ff == half - 4'h1)
      begin
        div_ff <= 4'h0;
        timer_in <= !timer_in;
      end
      else
        div_ff <= div_ff + 4'h1;
      last_ff <= pwm_pin;
      cnt_ff <= (pwm_pin && !last_ff) ? 16'h1 : cnt_ff + 16'h1;
      if (pwm_pin && !last_ff)
        period <= cnt_ff;
      if (!pwm_pin && last_ff)
        high_len <= cnt_ff;
    end
endmodule

// *** arpct_monitor.sv ***
`timescale 1ns/1ps
`include "arpct_defs.svh"
module arpct_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Pins and request
  input wire logic        timer_in,
  input wire logic        port_dout,
  input wire logic        pwm_pin,
  input wire logic        timer_irq
);
  localparam logic [11:0] a_md = {2'h0, `ARPCT_IDX_MODE, 2'h0};
  localparam logic [11:0] a_st = {2'h0, `ARPCT_IDX_STATUS, 2'h0};
  localparam logic [11:0] a_ld = {2'h0, `ARPCT_IDX_LOAD, 2'h0};
  logic [7:0] mode_ff;
  logic [7:0] lw_ff;
  logic       wr;
  logic       rd;
  logic       clr_wr;
  logic       frz;
  // Shadows of written values, since the checker cannot see inside
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign clr_wr = wr && (paddr == a_st || paddr == a_md);
  assign frz = mode_ff[5] && !mode_ff[6];
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      mode_ff <= 8'h00;
      lw_ff <= 8'h00;
    end
    else if (wr)
    begin
      if (paddr == a_md)
        mode_ff <= pwdata[7:0];
      if (paddr == a_ld)
        lw_ff <= pwdata[7:0];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Load write with the timer stopped in auto-reload mode, then a read
  sequence ld_wr;
    wr && paddr == a_ld && !mode_ff[6] && mode_ff[1:0] == 2'h0;
  endsequence
  sequence ld_setup;
    psel && !penable && !pwrite && paddr == a_ld;
  endsequence
  reset_quiet_a: assert property ($fell(rst) |-> !timer_irq && prdata == 32'h0)
    else $error("request or read data not clear after reset");
  load_trig_zero_a: assert property (rd && paddr == a_md |-> !prdata[7])
    else $error("load trigger bit read back as one");
  status_unused_a: assert property (rd && paddr == a_st |-> prdata[7:3] == 5'h0)
    else $error("unused status bits read as nonzero");
  load_readback_a: assert property (ld_wr ##2 ld_setup |=> prdata[7:0] == lw_ff)
    else $error("load register read differs from value written");
  pin_port_a: assert property (!mode_ff[5] |-> pwm_pin == port_dout)
    else $error("pin not showing port data while output disabled");
  irq_masked_a: assert property (mode_ff[4:2] == 3'h0 |-> !timer_irq)
    else $error("request raised with all enables clear");
  irq_sticky_a: assert property ($fell(timer_irq) |-> $past(clr_wr))
    else $error("request dropped without a flag or enable write");
  frozen_out_a: assert property (frz && $past(frz) |-> $stable(pwm_pin))
    else $error("output changed while counting disabled");
endmodule
bind arpct_timer arpct_monitor i_arpct_monitor (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .prdata, .timer_in, .port_dout, .pwm_pin, .timer_irq);

// *** arpct_pin_sync.sv ***
`timescale 1ns/1ps
module arpct_pin_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous pin
  input  wire logic pin,
  // Synchronised level and edge pulses
  output logic      level,
  output logic      rise,
  output logic      fall
);

  arpct_pkg::arpct_sync_s state_ff;
  arpct_pkg::arpct_sync_s nxt_state;

  // Two flops before use; the first feeds only the second
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_state.meta = pin;
    nxt_state.sync = state_ff.meta;
    nxt_state.last = state_ff.sync;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // Edges seen between the second and third flop
  assign level = state_ff.sync;
  assign rise  = state_ff.sync & ~state_ff.last;
  assign fall  = ~state_ff.sync & state_ff.last;

endmodule

// *** arpct_pkg.sv ***
package arpct_pkg;

  // Operating modes, in mode field order
  typedef enum logic [1:0] {
    ARPCT_AUTO_RELOAD,
    ARPCT_CAPTURE,
    ARPCT_CAPTURE_RESET,
    ARPCT_EXT_LOAD
  } arpct_mode_e;

  // Clock sources, in clock select order
  typedef enum logic [1:0] {
    ARPCT_CLK_INT,
    ARPCT_CLK_DIV3,
    ARPCT_CLK_PIN,
    ARPCT_CLK_NONE
  } arpct_clk_e;

  // Pin synchroniser state
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } arpct_sync_s;

  // Timer state
  typedef struct packed {
    logic        count_en;
    logic        pwm_oe;
    logic        edge_ie;
    logic        cmp_ie;
    logic        ovf_ie;
    arpct_mode_e mode;
    logic        edge_flag;
    logic        cmp_flag;
    logic        ovf_flag;
    logic [2:0]  ps_sel;
    logic        edge_pol;
    logic        edge_en;
    arpct_clk_e  clk_sel;
    logic [7:0]  reload;
    logic [7:0]  compare;
    logic [7:0]  counter;
    logic [6:0]  psc;
    logic [1:0]  div3;
    logic        pwm;
    logic [31:0] prdata;
  } arpct_state_s;

endpackage

// *** arpct_timer.sv ***
// How it works
// RULE1: 8-bit up-counter stepped by prescaler output
// RULE2: Clock from internal, internal/3 or pin
// RULE3: 7-bit prescaler, tap selects 2^n division
// RULE4: Count enable clear freezes prescaler and counter
// RULE5: Reset clears the counter
// RULE6: Load register write loads; read gives count
// RULE7: Every counter load clears the prescaler
// RULE8: Auto-reload overflow reloads and raises output
// RULE9: Compare match lowers output, sets flag
// RULE10: Overflow sets sticky flag, optional interrupt
// RULE11: Software writes reload then trigger plus enable
// RULE12: Capture modes copy count on active edge
// RULE13: Capture mode free-runs; overflow high, match low
// RULE14: Capture-with-reset also clears counter, prescaler
// RULE15: External-load mode loads reload on edge
// RULE16: Software avoids pin clock in capture modes
// RULE17: Software keeps clock settings while running
// RULE18: Software keeps compare above reload value
// RULE19: Writing 06h clears overflow flag only
// RULE20: Keeps running during processor wait
// RULE21: Two-bit field selects one of four modes
// RULE22: Edge detect enable bit and polarity bit
// RULE23: Flags cleared by writing zero; FFh to 00h
// RULE24: Load trigger write-only, reads zero, loads counter
// RULE25: Interrupt is OR of enabled flags
// RULE26: Pin shows timer output only when enabled
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "arpct_defs.svh"
module arpct_timer
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Timer input pin
  input  wire logic        timer_in,
  // Output pin and its ordinary port data
  input  wire logic        port_dout,
  output logic             pwm_pin,
  // Interrupt request
  output logic             timer_irq
);

  arpct_pkg::arpct_state_s state_ff;
  arpct_pkg::arpct_state_s nxt_state;

  // Pin edges from the synchroniser
  logic       pin_rise;
  logic       pin_fall;

  // Register bus decode
  logic       acc_wr;
  logic       setup;
  logic       mapped;
  logic [7:0] idx;
  logic [7:0] wdat;

  // Counting chain
  logic       src_tick;
  logic       cnt_tick;
  logic [6:0] tap_mask;
  logic       overflow;
  logic       edge_evt;
  logic [7:0] cnt_next;
  logic       cmp_hit;

  // Pin synchroniser, also usable as a clock source; the pin is only
  // sampled, so a pin clock above half the clk rate loses edges
  arpct_pin_sync i_arpct_pin_sync
  (
    .clk   (clk),
    .rst   (rst),
    .pin   (timer_in),
    .level (),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // Bus decode; zero wait states so pready is simply the access phase.
  // Only the low byte of pwdata carries data, the rest is ignored.
  // An unmapped or misaligned address answers with pslverr and is
  // otherwise ignored, so a stray write cannot disturb the timer.
  assign idx     = paddr[9:2];
  assign wdat    = pwdata[7:0];
  assign setup   = psel & ~penable;
  assign acc_wr  = psel & penable & pwrite & mapped;
  assign mapped  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                   (idx == `ARPCT_IDX_MODE || idx == `ARPCT_IDX_STATUS ||
                    idx == `ARPCT_IDX_CONFIG || idx == `ARPCT_IDX_RELOAD ||
                    idx == `ARPCT_IDX_COMPARE || idx == `ARPCT_IDX_LOAD);
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  // Read data comes straight from a flop loaded in the setup cycle
  assign prdata  = state_ff.prdata;

  // Source tick; the pin source is sampled on this clock, so it keeps
  // running without processor activity but needs clk alive.
  // Divide-by-three is a free modulo-3 count, so its first tick after a
  // switch comes within three cycles; the reserved code stops the timer.
  always_comb
  begin
    unique case (state_ff.clk_sel)
      arpct_pkg::ARPCT_CLK_INT:  src_tick = 1'b1; // RULE2 RULE20
      arpct_pkg::ARPCT_CLK_DIV3: src_tick = (state_ff.div3 == `ARPCT_DIV3_LAST);
      arpct_pkg::ARPCT_CLK_PIN:  src_tick = pin_rise;
      arpct_pkg::ARPCT_CLK_NONE: src_tick = 1'b0;
    endcase
  end

  // Tap n passes one tick in 2^n: all lower prescaler bits set.
  // Testing the low bits instead of using a prescaler bit as a clock
  // keeps every step a one-cycle enable on clk, with no derived clocks.
  assign tap_mask = 7'((8'h01 << state_ff.ps_sel) - 8'h01); // RULE3
  assign cnt_tick = state_ff.count_en & src_tick &
                    ((state_ff.psc & tap_mask) == tap_mask); // RULE4 RULE1
  // Overflow is the step from FFh; where the count goes depends on mode
  assign overflow = cnt_tick && (state_ff.counter == 8'hff); // RULE23
  assign cnt_next = overflow ?
                    ((state_ff.mode == arpct_pkg::ARPCT_AUTO_RELOAD) ?
                     state_ff.reload : 8'h00) :
                    8'(state_ff.counter + 8'h01);
  // Compare looks at the value about to be stored, so flag, pin and
  // counter all change on the same edge; software and edge loads never match
  assign cmp_hit  = cnt_tick && (cnt_next == state_ff.compare); // RULE9
  // Enable gates edge detection; polarity picks rising or falling
  assign edge_evt = state_ff.edge_en &
                    (state_ff.edge_pol ? pin_fall : pin_rise); // RULE22

  // Next state: counting first, then edge actions, then software loads
  always_comb
  begin
    nxt_state      = state_ff;

    // Divide-by-three count runs whatever the enable
    nxt_state.div3 = (state_ff.div3 == `ARPCT_DIV3_LAST) ? 2'h0 :
                     2'(state_ff.div3 + 2'h1);

    // Counting path
    if (state_ff.count_en && src_tick)
      nxt_state.psc = 7'(state_ff.psc + 7'h01); // RULE3
    if (cnt_tick)
    begin
      nxt_state.counter = cnt_next; // RULE1
      // An auto-reload is a counter load, so the prescaler restarts too
      if (overflow && state_ff.mode == arpct_pkg::ARPCT_AUTO_RELOAD)
        nxt_state.psc = 7'h00; // RULE8 RULE7
    end

    // Output: overflow raises, match lowers; match wins if both, so a
    // compare value equal to the reload value holds the output low in auto-reload mode
    if (overflow)
      nxt_state.pwm = 1'b1; // RULE8 RULE13
    if (cmp_hit)
      nxt_state.pwm = 1'b0; // RULE9 RULE13

    // Edge actions by mode; a capture takes the count before this
    // cycle's step, and in auto-reload mode an edge only sets its flag
    if (edge_evt)
    begin
      unique case (state_ff.mode)
        arpct_pkg::ARPCT_AUTO_RELOAD: ;
        arpct_pkg::ARPCT_CAPTURE:
          nxt_state.reload = state_ff.counter; // RULE12
        arpct_pkg::ARPCT_CAPTURE_RESET:
        begin
          nxt_state.reload  = state_ff.counter; // RULE12
          nxt_state.counter = 8'h00; // RULE14
          nxt_state.psc     = 7'h00; // RULE14
        end
        arpct_pkg::ARPCT_EXT_LOAD:
        begin
          nxt_state.counter = state_ff.reload; // RULE15
          nxt_state.psc     = 7'h00; // RULE7
        end
      endcase
    end

    // Register writes take effect on the access edge. They come last,
    // so a software load beats a count step or an edge in one cycle
    if (acc_wr)
    begin
      if (idx == `ARPCT_IDX_MODE)
      begin
        nxt_state.count_en = wdat[`ARPCT_MC_COUNT_EN];
        nxt_state.pwm_oe   = wdat[`ARPCT_MC_PWM_OE];
        nxt_state.edge_ie  = wdat[`ARPCT_MC_EDGE_IE];
        nxt_state.cmp_ie   = wdat[`ARPCT_MC_CMP_IE];
        nxt_state.ovf_ie   = wdat[`ARPCT_MC_OVF_IE];
        nxt_state.mode     = arpct_pkg::arpct_mode_e'(
                               wdat[`ARPCT_MC_MODE_HI:`ARPCT_MC_MODE_LO]); // RULE21
        if (wdat[`ARPCT_MC_LOAD_TRIG])
        begin
          nxt_state.counter = state_ff.reload; // RULE24
          nxt_state.psc     = 7'h00; // RULE7
        end
      end

      // Reserved config bit 4 is not stored and reads zero
      if (idx == `ARPCT_IDX_CONFIG)
      begin
        nxt_state.ps_sel   = wdat[`ARPCT_CF_PS_HI:`ARPCT_CF_PS_LO];
        nxt_state.edge_pol = wdat[`ARPCT_CF_POL];
        nxt_state.edge_en  = wdat[`ARPCT_CF_EDGE_EN];
        nxt_state.clk_sel  = arpct_pkg::arpct_clk_e'(
                               wdat[`ARPCT_CF_CS_HI:`ARPCT_CF_CS_LO]);
      end

      // A capture in the same cycle beats a software reload write
      if (idx == `ARPCT_IDX_RELOAD && !(edge_evt &&
          (state_ff.mode == arpct_pkg::ARPCT_CAPTURE ||
           state_ff.mode == arpct_pkg::ARPCT_CAPTURE_RESET)))
        nxt_state.reload = wdat;
      if (idx == `ARPCT_IDX_COMPARE)
        nxt_state.compare = wdat;

      // Load register write: the counter takes the value at once
      if (idx == `ARPCT_IDX_LOAD)
      begin
        nxt_state.counter = wdat; // RULE6
        nxt_state.psc     = 7'h00; // RULE7
      end
    end

    // Sticky flags: write zero clears, one keeps, and a new event wins
    // Setting after the clear keeps an overflow that meets a 06h write
    if (acc_wr && idx == `ARPCT_IDX_STATUS)
    begin
      nxt_state.edge_flag = state_ff.edge_flag & wdat[`ARPCT_ST_EDGE]; // RULE23 RULE19
      nxt_state.cmp_flag  = state_ff.cmp_flag & wdat[`ARPCT_ST_CMP]; // RULE23
      nxt_state.ovf_flag  = state_ff.ovf_flag & wdat[`ARPCT_ST_OVF]; // RULE23
    end
    if (edge_evt)
      nxt_state.edge_flag = 1'b1; // RULE12
    if (cmp_hit)
      nxt_state.cmp_flag = 1'b1; // RULE9
    if (overflow)
      nxt_state.ovf_flag = 1'b1; // RULE10

    // Read data captured in the setup cycle, valid through the access
    // Writes and unmapped reads leave zero, so stale data never shows
    if (setup)
    begin
      nxt_state.prdata = 32'h0;
      if (!pwrite && mapped)
      begin
        unique case (idx)
          // Load trigger is write-only and always reads zero
          `ARPCT_IDX_MODE:
            nxt_state.prdata[7:0] = {1'b0, state_ff.count_en, state_ff.pwm_oe, // RULE24
                                     state_ff.edge_ie, state_ff.cmp_ie,
                                     state_ff.ovf_ie, state_ff.mode};
          `ARPCT_IDX_STATUS:
            nxt_state.prdata[7:0] = {5'h00, state_ff.edge_flag,
                                     state_ff.cmp_flag, state_ff.ovf_flag};
          `ARPCT_IDX_CONFIG:
            nxt_state.prdata[7:0] = {state_ff.ps_sel, 1'b0, state_ff.edge_pol,
                                     state_ff.edge_en, state_ff.clk_sel};
          `ARPCT_IDX_RELOAD:  nxt_state.prdata[7:0] = state_ff.reload;
          `ARPCT_IDX_COMPARE: nxt_state.prdata[7:0] = state_ff.compare;
          // Load register read gives the live count
          `ARPCT_IDX_LOAD:    nxt_state.prdata[7:0] = state_ff.counter; // RULE6
          default:            nxt_state.prdata[7:0] = 8'h00;
        endcase
      end
    end
  end

  // State register; the reset branch loads constants only, with the
  // enum fields named so the reset state reads clearly
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff          <= '0;
      state_ff.mode     <= arpct_pkg::ARPCT_AUTO_RELOAD;
      state_ff.clk_sel  <= arpct_pkg::ARPCT_CLK_INT;
      state_ff.reload   <= `ARPCT_RST_RELOAD;
      state_ff.compare  <= `ARPCT_RST_COMPARE;
      state_ff.counter  <= `ARPCT_RST_COUNTER; // RULE5
    end
    else
      state_ff <= nxt_state;
  end

  // Interrupt is a level held until the flags are cleared
  // There is no pulse stretching: the request goes as soon as software
  // clears the flag or its enable
  assign timer_irq = (state_ff.edge_flag & state_ff.edge_ie) |
                     (state_ff.cmp_flag & state_ff.cmp_ie) |
                     (state_ff.ovf_flag & state_ff.ovf_ie); // RULE25

  // Pin falls back to its port function when the output is disabled
  // The mux is combinational, so the port data reaches the pin at once
  assign pwm_pin = state_ff.pwm_oe ? state_ff.pwm : port_dout; // RULE26

endmodule

// *** test_arpct_timer.sv ***
`timescale 1ns/1ps
`include "arpct_defs.svh"
module test_arpct_timer;
  localparam logic [7:0] ix_md = `ARPCT_IDX_MODE;
  localparam logic [7:0] ix_st = `ARPCT_IDX_STATUS;
  localparam logic [7:0] ix_cf = `ARPCT_IDX_CONFIG;
  localparam logic [7:0] ix_rl = `ARPCT_IDX_RELOAD;
  localparam logic [7:0] ix_cp = `ARPCT_IDX_COMPARE;
  localparam logic [7:0] ix_ld = `ARPCT_IDX_LOAD;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        port_dout = 1'b0;
  logic        lvl = 1'b0;
  logic [3:0]  half = 4'h0;
  logic        pready, pslverr, timer_in, pwm_pin, timer_irq;
  logic [31:0] prdata;
  logic [15:0] period, high_len;
  logic [32:0] exp_q[$];
  logic [7:0]  v, c1, c2, c3;
  integer      seed = 87;
  integer      fail_count = 0;
  integer      n_tests = 0;
  integer      cyc = 0;
  int          per[5] = '{16, 32, 64, 48, 64};
  logic [7:0]  cfg[5] = '{8'h00, 8'h20, 8'h40, 8'h01, 8'h02};
  logic [7:0]  ids[6] = '{ix_md, ix_st, ix_cf, ix_rl, ix_cp, ix_ld};

  arpct_timer i_arpct_timer (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .timer_in(timer_in), .port_dout(port_dout), .pwm_pin(pwm_pin),
    .timer_irq(timer_irq));
  arpct_far_end i_arpct_far_end (.clk(clk), .rst(rst), .lvl(lvl), .half(half),
    .pwm_pin(pwm_pin), .timer_in(timer_in), .period(period), .high_len(high_len));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Note pushed after setup so the watcher never pairs it with an older raw read
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d,
                     input logic q, input logic [32:0] e, output logic [7:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    if (q)
      exp_q.push_back(e);
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d, 1'b0, 33'h0, v);
  endtask

  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h0, 1'b1, {25'h0, e}, c3);
  endtask

  // One rising edge on the pin, capture read, rises kept 40 cycles apart
  task automatic edge_rd(output logic [7:0] c);
    integer t0;
    t0 = cyc;
    lvl <= 1'b1;
    repeat (8) @(posedge clk);
    lvl <= 1'b0;
    apb(1'b0, ix_rl, 8'h0, 1'b0, 33'h0, c);
    while (cyc < t0 + 40)
      @(posedge clk);
  endtask

  // Watcher: each finished read takes the oldest note
  always @(posedge clk)
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() != 0)
      chk({pslverr, prdata}, exp_q.pop_front());

  // Cycle count, random port data, and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    port_dout <= 1'($random(seed));
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test;
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(ids[i], 8'h00);
    apb(1'b0, 8'hd8, 8'h0, 1'b1, {1'b1, 32'h0}, c3);
    $display("reset values done");
    v = 8'($random(seed));
    c1 = v;
    wr(ix_ld, c1);
    rd(ix_ld, c1);
    repeat (20) @(posedge clk);
    rd(ix_ld, c1);
    c2 = 8'($random(seed));
    wr(ix_rl, c2);
    wr(ix_md, 8'h80);
    rd(ix_ld, c2);
    rd(ix_md, 8'h00);
    $display("load paths done");
    wr(ix_rl, 8'hf0);
    wr(ix_cp, 8'hf8);
    for (int k = 0; k < 5; k++)
    begin
      wr(ix_md, 8'h2c);
      wr(ix_cf, cfg[k]);
      half <= (k == 4) ? 4'h2 : 4'h0;
      wr(ix_md, 8'hec);
      repeat (4 * per[k] + 40) @(posedge clk);
      chk({17'h0, period}, 33'(per[k]));
      chk({17'h0, high_len}, 33'(per[k] / 2));
    end
    wr(ix_md, 8'h2c);
    half <= 4'h0;
    rd(ix_st, 8'h03);
    wr(ix_st, 8'h06);
    rd(ix_st, 8'h02);
    chk({32'h0, timer_irq}, 33'h1);
    wr(ix_st, 8'h00);
    rd(ix_st, 8'h00);
    chk({32'h0, timer_irq}, 33'h0);
    $display("pwm and flags done");
    wr(ix_cf, 8'h04);
    wr(ix_md, 8'h41);
    edge_rd(c1);
    edge_rd(c2);
    chk({25'h0, c2}, {25'h0, c1 + 8'd40});
    apb(1'b0, ix_st, 8'h0, 1'b0, 33'h0, c3);
    chk({32'h0, c3[2]}, 33'h1);
    wr(ix_st, 8'h06);
    apb(1'b0, ix_st, 8'h0, 1'b0, 33'h0, c3);
    chk({32'h0, c3[2]}, 33'h1);
    wr(ix_md, 8'h42);
    edge_rd(c1);
    edge_rd(c2);
    edge_rd(c3);
    chk({25'h0, c3}, {25'h0, c2});
    v = 8'($random(seed)) | 8'h01;
    c1 = v;
    wr(ix_rl, c1);
    wr(ix_cf, 8'h0c);
    wr(ix_md, 8'h03);
    wr(ix_ld, 8'h00);
    lvl <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ix_ld, 8'h00);
    lvl <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ix_ld, c1);
    $display("capture and edge load done");
    stop_test;
  end
endmodule
